//--- verilog/fbc_consts.svh
// shared offsets, field positions, opcodes and timing counts for the flash command block
`ifndef FBC_CONSTS_SVH
`define FBC_CONSTS_SVH

// word index of each non-volatile register inside the storage memory
`define FBC_NV_BOOT       1'h0
`define FBC_NV_BANK       1'h1

// boot_stream_config layout
`define FBC_BC_EN         0
`define FBC_BC_DLY_LO     1
`define FBC_BC_DLY_HI     4
`define FBC_BC_ADR_LO     5
`define FBC_BC_RST        32'h0000_0000

// bank_address_upper layout
`define FBC_BAR_EXT       7
`define FBC_BAR_RST       8'h00

// opcodes
`define FBC_OP_WRITE_ENABLE_CMD       8'h06
`define FBC_OP_RELOCK     8'h24
`define FBC_OP_BOOT_RD    8'h14
`define FBC_OP_BOOT_WR    8'h15
`define FBC_OP_BANK_RD    8'h16
`define FBC_OP_BANK_RD2   8'hC8
`define FBC_OP_BANK_NV    8'h18
`define FBC_OP_BANK_VOL   8'h17
`define FBC_OP_BANK_VOL2  8'hC5
`define FBC_OP_WIDE_ON    8'hB7
`define FBC_OP_WIDE_OFF   8'h29
`define FBC_OP_DYB_RD     8'hFA
`define FBC_OP_DYB_RD_W   8'hE0

// bit counts of a whole frame or, for the ADDR values, up to the end of the address, opcode included
`define FBC_CMD_BITS      8'h08
`define FBC_BANK_WR_BITS  8'h10
`define FBC_BOOT_WR_BITS  8'h28
`define FBC_ADDR3_END     8'h20
`define FBC_ADDR4_END     8'h28

// dynamic protection byte values
`define FBC_DYB_PROT      8'h00
`define FBC_DYB_OPEN      8'hFF

// timing
`define FBC_MCLK_MHZ      25
`define FBC_NV_WR_NS      10000
`define FBC_NV_WR_CYC     (((`FBC_NV_WR_NS * `FBC_MCLK_MHZ) + 999) / 1000)

`endif

//--- verilog/fbc_pkg.sv
// types for the flash command block
package fbc_pkg;
    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DIN, PH_OUT, PH_IGN, PH_BDLY, PH_BSTR} fbc_ph_e;
    typedef enum logic [1:0] {LD_CFG, LD_BANK, LD_FIN, LD_DONE} fbc_ld_e;
endpackage

//--- verilog/fbc_nvmem.sv
// small non-volatile word store with registered read data
`timescale 1ns/10ps
module fbc_nvmem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2,
    parameter int AW    = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // contents model storage that survives reset, so only power-on clears them
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule // fbc_nvmem

//--- verilog/fbc_fifo.sv
// small valid/ready buffer with a registered fill-side ready
`timescale 1ns/10ps
module fbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic             en_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign cnt_nxt     = (AW + 1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});

    // disabling flushes the contents; ready is computed ahead so it stays a flop
    always_ff @(posedge mclk_i) begin
        if (srst_i || !en_i) begin
            cnt_r      <= '0;
            wp_r       <= '0;
            rp_r       <= '0;
            in_ready_o <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            in_ready_o <= (cnt_nxt < (AW + 1)'(DEPTH));
            if (push) begin
                wp_r <= step(wp_r);
            end
            if (pop) begin
                rp_r <= step(rp_r);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule // fbc_fifo

//--- verilog/fbc_top.sv
// serial flash command logic: boot streaming, bank addressing, relock and protection reads
`timescale 1ns/10ps
`include "fbc_consts.svh"
module fbc_top (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_n_i,
    input  wire logic        sck_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    input  wire logic        quad_enable_i,
    input  wire logic        quad_command_mode_i,
    input  wire logic        dyb_bit_i,
    input  wire logic        arr_valid_i,
    input  wire logic [7:0]  arr_data_i,
    output logic             arr_ready_o,
    output logic      [31:0] arr_addr_o,
    output logic      [31:0] dyb_addr_o,
    output logic      [7:0]  bank_addr_o,
    output logic             sector_relock_o,
    output logic             write_in_progress_o,
    output logic             write_enable_latch_o
);
    import fbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] bswap(input logic [31:0] w);
        bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic logic [31:0] rotl(input logic [31:0] w, input logic q);
        rotl = q ? {w[27:0], w[31:28]} : {w[30:0], w[31]};
    endfunction

    // single-line data leaves on io[1], quad data on all four lines
    function automatic logic [3:0] drive(input logic [31:0] w, input logic q);
        drive = q ? w[31:28] : {2'b00, w[31], 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0]  sck_s_r;
    logic [2:0]  ce_s_r;
    logic [3:0]  io_m_r;
    logic [3:0]  io_s_r;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sck_s_r <= 3'h0;
            ce_s_r  <= 3'h7;
            io_m_r  <= 4'h0;
            io_s_r  <= 4'h0;
        end else begin
            sck_s_r <= {sck_s_r[1:0], sck_i};
            ce_s_r  <= {ce_s_r[1:0], ce_n_i};
            io_m_r  <= io_i;
            io_s_r  <= io_m_r;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic ce_act;
    logic ce_fall;
    logic ce_rise;
    assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
    assign sck_fall = ~sck_s_r[1] & sck_s_r[2];
    assign ce_act   = ~ce_s_r[1];
    assign ce_fall  = ~ce_s_r[1] & ce_s_r[2];
    assign ce_rise  = ce_s_r[1] & ~ce_s_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // state
    fbc_ph_e      ph_r;
    fbc_ld_e      ld_r;
    logic [31:0]  sr_r;
    logic [31:0]  sr_nxt;
    logic [7:0]   rcnt_r;
    logic [7:0]   rcnt_nxt;
    logic [7:0]   cmd_r;
    logic [3:0]   dcnt_r;
    logic         first_r;
    logic [2:0]   obit_r;
    logic [31:0]  tx_r;
    logic [31:0]  boot_cfg_r;
    logic [7:0]   bar_vol_r;
    logic         boot_armed_r;
    logic [11:0]  wip_cnt_r;
    logic [31:0]  nv_rdata;
    logic         qcm;
    logic         wide;
    logic [7:0]   addr_end;
    logic [3:0]   boot_dly;
    logic         exec;
    logic         nv_start;
    logic         boot_wr;
    logic         fetch_en;
    logic         buf_valid;
    logic [7:0]   buf_data;
    logic         pop;
    logic [31:0]  out_src;

    assign qcm      = quad_command_mode_i;
    assign sr_nxt   = qcm ? {sr_r[27:0], io_s_r} : {sr_r[30:0], io_s_r[0]};
    assign rcnt_nxt = (rcnt_r > 8'hF0) ? rcnt_r : 8'(rcnt_r + (qcm ? 8'h04 : 8'h01));
    assign wide     = (cmd_r == `FBC_OP_DYB_RD_W) | bar_vol_r[`FBC_BAR_EXT];
    assign addr_end = wide ? `FBC_ADDR4_END : `FBC_ADDR3_END;
    assign boot_dly = boot_cfg_r[`FBC_BC_DLY_HI:`FBC_BC_DLY_LO];

    function automatic fbc_ph_e decode(input logic [7:0] op);
        case (op)
            `FBC_OP_BOOT_RD, `FBC_OP_BANK_RD, `FBC_OP_BANK_RD2: decode = PH_OUT;
            `FBC_OP_DYB_RD, `FBC_OP_DYB_RD_W:                    decode = PH_ADDR;
            `FBC_OP_BOOT_WR, `FBC_OP_BANK_NV, `FBC_OP_BANK_VOL,
            `FBC_OP_BANK_VOL2:                                   decode = PH_DIN;
            default:                                             decode = PH_IGN;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencing on the serial clock
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ph_r    <= PH_CMD;
            rcnt_r  <= 8'h00;
            sr_r    <= 32'h0;
            cmd_r   <= 8'h00;
            dcnt_r  <= 4'h0;
            first_r <= 1'b1;
        end else if (ce_fall) begin
            rcnt_r  <= 8'h00;
            dcnt_r  <= 4'h0;
            first_r <= 1'b1;
            if (boot_armed_r) begin
                ph_r <= (boot_dly == 4'h0) ? PH_BSTR : PH_BDLY;
            end else begin
                ph_r <= PH_CMD;
            end
        end else if (ce_act && sck_rise) begin
            sr_r   <= sr_nxt;
            rcnt_r <= rcnt_nxt;
            case (ph_r)
                PH_CMD: if (rcnt_nxt == `FBC_CMD_BITS) begin
                    cmd_r <= sr_nxt[7:0];
                    ph_r  <= decode(sr_nxt[7:0]);
                end
                PH_ADDR: if (rcnt_nxt == addr_end) begin
                    ph_r <= PH_OUT;
                end
                // input lines are not decoded while the delay counts down
                PH_BDLY: begin
                    dcnt_r <= 4'(dcnt_r + 4'h1);
                    if (4'(dcnt_r + 4'h1) == boot_dly) begin
                        ph_r <= PH_BSTR;
                    end
                end
                default: ;
            endcase
        end else if (ce_act && sck_fall && (ph_r == PH_OUT || ph_r == PH_BSTR)) begin
            first_r <= 1'b0;
        end
    end

    // upper address from the bank register unless extended addressing
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dyb_addr_o <= 32'h0;
        end else if (ce_act && sck_rise && ph_r == PH_ADDR && rcnt_nxt == addr_end) begin
            dyb_addr_o <= wide ? sr_nxt : {1'b0, bar_vol_r[6:0], sr_nxt[23:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output shifting on falling serial clock
    // an 8-bit value is replicated four times so one 32-bit rotate serves every read
    always_comb begin
        out_src = 32'h0;
        if (cmd_r == `FBC_OP_BOOT_RD) begin
            out_src = bswap(boot_cfg_r);
        end else if (cmd_r == `FBC_OP_BANK_RD || cmd_r == `FBC_OP_BANK_RD2) begin
            out_src = {4{bar_vol_r}};
        end else begin
            out_src = {4{dyb_bit_i ? `FBC_DYB_OPEN : `FBC_DYB_PROT}};
        end
    end

    logic [31:0] tx_word;
    logic        tx_q;
    always_comb begin
        tx_q    = qcm;
        tx_word = first_r ? out_src : tx_r;
        if (ph_r == PH_BSTR) begin
            tx_q    = quad_enable_i;
            tx_word = (obit_r == 3'h0) ? {buf_data, 24'h0} : tx_r;
        end
    end

    assign pop = ce_act & sck_fall & (ph_r == PH_BSTR) & (obit_r == 3'h0) & buf_valid;

    always_ff @(posedge mclk_i) begin
        if (srst_i || !ce_act) begin
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
            tx_r    <= 32'h0;
            obit_r  <= 3'h0;
        end else if (sck_fall && (ph_r == PH_OUT || ph_r == PH_BSTR)) begin
            io_o    <= drive(tx_word, tx_q);
            io_oe_o <= tx_q ? 4'hF : 4'h2;
            tx_r    <= rotl(tx_word, tx_q);
            obit_r  <= 3'(obit_r + (tx_q ? 3'h4 : 3'h1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command execution at deselect
    assign exec     = ce_rise && ld_r == LD_DONE && ph_r != PH_BDLY && ph_r != PH_BSTR;
    assign boot_wr  = (cmd_r == `FBC_OP_BOOT_WR) && (rcnt_r == `FBC_BOOT_WR_BITS);
    assign nv_start = exec && write_enable_latch_o && !write_in_progress_o &&
                      (boot_wr || (cmd_r == `FBC_OP_BANK_NV && rcnt_r == `FBC_BANK_WR_BITS));

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ld_r         <= LD_CFG;
            boot_cfg_r   <= `FBC_BC_RST;
            bar_vol_r    <= `FBC_BAR_RST;
            boot_armed_r <= 1'b0;
        end else begin
            case (ld_r)
                LD_CFG:  ld_r <= LD_BANK;
                LD_BANK: begin
                    boot_cfg_r <= nv_rdata;
                    ld_r       <= LD_FIN;
                end
                LD_FIN: begin
                    bar_vol_r    <= nv_rdata[7:0];
                    boot_armed_r <= boot_cfg_r[`FBC_BC_EN];
                    ld_r         <= LD_DONE;
                end
                default: if (ce_rise) begin
                    boot_armed_r <= 1'b0;
                    if (nv_start && boot_wr) begin
                        boot_cfg_r <= bswap(sr_r);
                    end
                    if (exec && rcnt_r == `FBC_BANK_WR_BITS &&
                        (nv_start || cmd_r == `FBC_OP_BANK_VOL || cmd_r == `FBC_OP_BANK_VOL2)) begin
                        bar_vol_r <= sr_r[7:0];
                    end
                    if (exec && rcnt_r == `FBC_CMD_BITS && cmd_r == `FBC_OP_WIDE_ON) begin
                        bar_vol_r[`FBC_BAR_EXT] <= 1'b1;
                    end
                    if (exec && rcnt_r == `FBC_CMD_BITS && cmd_r == `FBC_OP_WIDE_OFF) begin
                        bar_vol_r[`FBC_BAR_EXT] <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sector_relock_o <= 1'b0;
            bank_addr_o     <= `FBC_BAR_RST;
        end else begin
            sector_relock_o <= exec && rcnt_r == `FBC_CMD_BITS && cmd_r == `FBC_OP_RELOCK;
            bank_addr_o     <= bar_vol_r;
        end
    end

    // busy models the program time; the storage itself is written at the start
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            write_in_progress_o  <= 1'b0;
            write_enable_latch_o <= 1'b0;
            wip_cnt_r            <= 12'h000;
        end else if (write_in_progress_o) begin
            if (wip_cnt_r == 12'h000) begin
                write_in_progress_o  <= 1'b0;
                write_enable_latch_o <= exec && rcnt_r == `FBC_CMD_BITS && cmd_r == `FBC_OP_WRITE_ENABLE_CMD;
            end else begin
                wip_cnt_r <= 12'(wip_cnt_r - 12'h001);
            end
        end else if (nv_start) begin
            write_in_progress_o <= 1'b1;
            wip_cnt_r           <= 12'(`FBC_NV_WR_CYC - 1);
        end else if (exec && rcnt_r == `FBC_CMD_BITS && cmd_r == `FBC_OP_WRITE_ENABLE_CMD) begin
            write_enable_latch_o <= 1'b1;
        end
    end

    fbc_nvmem #(
        .WIDTH (32),
        .DEPTH (2),
        .AW    (1)
    ) u_nvmem (
        .mclk_i  (mclk_i),
        .we_i    (nv_start),
        .waddr_i (boot_wr ? `FBC_NV_BOOT : `FBC_NV_BANK),
        .wdata_i (boot_wr ? bswap(sr_r) : {24'h0, sr_r[7:0]}),
        .raddr_i ((ld_r == LD_CFG) ? `FBC_NV_BOOT : `FBC_NV_BANK),
        .rdata_o (nv_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // boot prefetch from the array into the buffer
    assign fetch_en = boot_armed_r && ld_r == LD_DONE;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            arr_addr_o <= 32'h0;
        end else if (ld_r == LD_FIN) begin
            arr_addr_o <= {boot_cfg_r[31:`FBC_BC_ADR_LO], 5'h00};
        end else if (arr_valid_i && arr_ready_o) begin
            arr_addr_o <= 32'(arr_addr_o + 32'h1);
        end
    end

    fbc_fifo #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .en_i        (fetch_en),
        .in_valid_i  (arr_valid_i),
        .in_ready_o  (arr_ready_o),
        .in_data_i   (arr_data_i),
        .out_valid_o (buf_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_data)
    );
endmodule // fbc_top

//--- bench/fbc_chk_props.sv
// concurrent checks on the ports of the flash command block
`timescale 1ns/10ps
module fbc_chk (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_n_i,
    input  wire logic        quad_enable_i,
    input  wire logic        quad_command_mode_i,
    input  wire logic        arr_valid_i,
    input  wire logic        arr_ready_o,
    input  wire logic [31:0] arr_addr_o,
    input  wire logic [3:0]  io_oe_o,
    input  wire logic        sector_relock_o,
    input  wire logic        write_in_progress_o,
    input  wire logic        write_enable_latch_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // non-volatile update lasts 250 cycles; slack of a few cycles at the end
    sequence busy_run;
        write_in_progress_o throughout ##240 1'b1;
    endsequence
    sequence busy_end;
        ##[1:12] !write_in_progress_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    relock_pulse_a: assert property (sector_relock_o |=> !sector_relock_o)
        else $error("relock pulse longer than one cycle");
    relock_frame_a: assert property (sector_relock_o |-> ce_n_i)
        else $error("relock fired inside a frame");
    wel_at_ce_a: assert property ($rose(write_enable_latch_o) |-> ce_n_i)
        else $error("write latch set inside a frame");
    busy_needs_wel_a: assert property ($rose(write_in_progress_o) |-> $past(write_enable_latch_o))
        else $error("busy started without write latch");
    busy_length_a: assert property ($rose(write_in_progress_o) |-> busy_run ##0 busy_end)
        else $error("busy length wrong");
    done_clears_wel_a: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o)
        else $error("write latch left set after update");
    out_idle_a: assert property (ce_n_i [*5] |-> io_oe_o == 4'h0)
        else $error("output driven while deselected");
    out_mode_a: assert property ((io_oe_o inside {4'h0, 4'h2}) || (io_oe_o == 4'hF && (quad_enable_i || quad_command_mode_i)))
        else $error("output lines wrong for mode");
    arr_step_a: assert property (arr_valid_i && arr_ready_o |=> arr_addr_o == $past(arr_addr_o) + 32'h1)
        else $error("fetch address did not step");
endmodule // fbc_chk

bind fbc_top fbc_chk chk_u (.mclk_i, .srst_i, .ce_n_i, .quad_enable_i, .quad_command_mode_i, .arr_valid_i,
    .arr_ready_o, .arr_addr_o, .io_oe_o, .sector_relock_o, .write_in_progress_o, .write_enable_latch_o);

//--- bench/fbc_host_model.sv
// mode-0 serial host that frames commands and collects read bits, on one line or on four
`timescale 1ns/10ps
module fbc_host_model (
    output logic            ce_n_o,
    output logic            sck_o,
    output logic      [3:0] io_o,
    input  wire logic [3:0] io_i
);
    initial begin
        ce_n_o = 1'b1;
        sck_o  = 1'b0;
        io_o   = 4'h5;
    end
    // sck stands low between frames; lines flip after a frame so stale data cannot pass
    // with quad set, nb counts clocks and each clock moves one nibble both ways
    task automatic frame(input int nb, input logic [79:0] din, input logic quad,
                         output logic [63:0] dout);
        dout   = '0;
        ce_n_o = 1'b0;
        #160;
        for (int i = nb - 1; i >= 0; i--) begin
            if (quad) begin
                io_o = din[i*4 +: 4];
            end else begin
                io_o[0] = din[i];
            end
            sck_o = 1'b0;
            #160;
            sck_o = 1'b1;
            dout  = quad ? {dout[59:0], io_i} : {dout[62:0], io_i[1]};
            #160;
        end
        sck_o = 1'b0;
        io_o  = ~io_o;
        #160;
        ce_n_o = 1'b1;
        #200;
    endtask
endmodule // fbc_host_model

//--- bench/tb_top.sv
// self-checking bench for the flash command block
`timescale 1ns/10ps
module tb_top;
    logic        mclk_i = 1'b0, srst_i = 1'b1, arr_valid_i = 1'b0, dyb_bit_i = 1'b0, qe = 1'b0, quad_command_mode = 1'b0;
    logic        ce_n, sck, sector_relock_o, write_in_progress_o, write_enable_latch_o, arr_ready_o;
    logic [3:0]  io_o, io_oe_o, h_io;
    wire  [3:0]  io_bus = (io_oe_o & io_o) | (~io_oe_o & h_io);
    logic [31:0] arr_addr_o, dyb_addr_o, cfg, a, s;
    logic [7:0]  arr_data_i, bank_addr_o, b, nvb, d;
    logic [63:0] q;
    int          n_mismatch = 0, checks_done = 0, rel_n = 0;
    logic [7:0]  vol_op [2] = '{8'h17, 8'hC5};
    logic [7:0]  rd_op  [2] = '{8'h16, 8'hC8};

    fbc_top dut_u (.mclk_i, .srst_i, .ce_n_i(ce_n), .sck_i(sck), .io_i(io_bus), .io_o, .io_oe_o,
        .quad_enable_i(qe), .quad_command_mode_i(quad_command_mode), .dyb_bit_i, .arr_valid_i, .arr_data_i, .arr_ready_o,
        .arr_addr_o, .dyb_addr_o, .bank_addr_o, .sector_relock_o, .write_in_progress_o, .write_enable_latch_o);
    fbc_host_model host_u (.ce_n_o(ce_n), .sck_o(sck), .io_o(h_io), .io_i(io_bus));

    initial forever #20 mclk_i = ~mclk_i;
    // array answers combinationally for the current fetch address, stalling at random
    assign arr_data_i = arr_addr_o[7:0] ^ arr_addr_o[15:8];
    always @(posedge mclk_i) begin
        #2;
        arr_valid_i = ($urandom % 4) != 0;
        if (sector_relock_o === 1'b1) rel_n++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] le(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function automatic logic [7:0] arr(input logic [31:0] v);
        return v[7:0] ^ v[15:8];
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("TB: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // frames start just after a clock edge so pins never move on the sampling edge
    task automatic xf(input int nb, input logic [79:0] din);
        @(posedge mclk_i);
        #2;
        host_u.frame(nb, din, quad_command_mode | qe, q);
    endtask
    task automatic do_reset();
        @(posedge mclk_i) #2 srst_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        #2 srst_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        #2;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400 && write_in_progress_o !== 1'b0; i++) begin
            @(posedge mclk_i);
            #2;
        end
        if (write_in_progress_o !== 1'b0) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8167395a));
        do_reset();
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom) & 8'h7F;
            xf(16, {vol_op[k], b});
            chk(write_in_progress_o, 1'b0, "busy vol");
            chk(bank_addr_o, b, "bank vol");
            xf(24, {rd_op[k], 16'h0});
            chk(q[15:0], {b, b}, "bank read");
        end
        // quad command mode: opcode, data and read data all move a nibble per clock
        quad_command_mode = 1'b1;
        b   = 8'($urandom) & 8'h7F;
        xf(4, {8'hC5, b});
        xf(6, {8'hC8, 16'h0});
        quad_command_mode = 1'b0;
        chk(q[15:0], {b, b}, "quad bank read");
        xf(8, 8'h24);
        xf(16, 16'h2400);
        chk(rel_n, 1, "relock count");
        for (int k = 0; k < 2; k++) begin
            dyb_bit_i = 1'($urandom);
            d = dyb_bit_i ? 8'hFF : 8'h00;
            a = $urandom & 32'h01FF_F000;
            xf(8, k ? 8'h29 : 8'hB7);
            chk(bank_addr_o[7], !k, "wide bit");
            xf(56, k ? {8'hFA, a[23:0], 24'h0} : {8'hFA, a, 16'h0});
            chk(dyb_addr_o, k ? {1'b0, b[6:0], a[23:0]} : a, "dyb addr");
            chk(q[15:0], {d, d}, "dyb data");
            xf(56, {8'hE0, a, 16'h0});
            chk(dyb_addr_o, a, "dyb wide addr");
        end
        nvb = 8'($urandom) & 8'h7F;
        xf(16, {8'h18, nvb});
        chk(bank_addr_o, b, "nv without latch");
        xf(8, 8'h06);
        chk(write_enable_latch_o, 1'b1, "latch set");
        xf(16, {8'h18, nvb});
        chk(write_in_progress_o, 1'b1, "nv busy");
        wait_idle();
        chk(bank_addr_o, nvb, "nv bank");
        xf(16, {8'h17, ~nvb & 8'h7F});
        xf(8, 8'hB7);
        do_reset();
        chk(bank_addr_o, nvb, "nv bank kept");
        xf(8, 8'h06);
        xf(39, {8'h15, 31'h0});
        chk(write_in_progress_o, 1'b0, "short boot write");
        for (int k = 0; k < 3; k++) begin
            cfg = {27'($urandom) & 27'h7FF, k ? 4'($urandom) : 4'h0, k != 2};
            s = {cfg[31:5], 5'h0};
            xf(8, 8'h06);
            xf(40, {8'h15, le(cfg)});
            chk(write_in_progress_o, 1'b1, "boot write busy");
            wait_idle();
            chk(write_enable_latch_o, 1'b0, "latch cleared");
            xf(72, {8'h14, 64'h0});
            chk(q, {le(cfg), le(cfg)}, "boot reg read");
            do_reset();
            if (k != 2) begin
                // mode 0 has no fall before the first rise, so a zero delay behaves as one
                qe = (k == 1);
                xf((cfg[4:1] == 4'h0 ? 1 : int'(cfg[4:1])) + (qe ? 4 : 16), 80'h0);
                qe = 1'b0;
                chk(q[15:0], {arr(s), arr(s + 32'h1)}, "boot stream");
            end
            xf(40, {8'h14, 32'h0});
            chk(q[31:0], le(cfg), "after boot");
        end
        end_of_test();
    end
endmodule // tb_top
